// ==== rtl/pife_defs.svh ====
/*
 * timing counts, field positions and command codes of the pulsar front end.
 * assumes a 200 mhz system clock.
 */
`ifndef PIFE_DEFS_SVH
`define PIFE_DEFS_SVH

`define PIFE_CLK_MHZ 200
`define PIFE_FILTER_MS 32
`define PIFE_FILTER_CYCLES (`PIFE_FILTER_MS * 1000 * `PIFE_CLK_MHZ)
`define PIFE_CMD_START_LOW 8'h50
`define PIFE_CMD_START_HIGH 8'h51
`define PIFE_CMD_IMMEDIATE_STOP 8'h49
`define PIFE_ENV2_DISABLE_BIT 31
`define PIFE_ENV2_SENSE_BIT 26
`define PIFE_ENV2_METHOD_LO 24
`define PIFE_ENV1_FILTER_BIT 27
`define PIFE_ERR_SIMUL_BIT 17
`define PIFE_ERR_OVERFLOW_BIT 14
`define PIFE_STATE_WAIT_INPUT 4'h8
`define PIFE_STATE_IDLE 4'h0
`define PIFE_DIV_FULL 12'h800
`define PIFE_BUF_MAX 16'hffff

`endif

// ==== rtl/pife_pkg.sv ====
/*
 * types shared by the pulsar front end files.
 * assumes the defs header for all numbers.
 */
package pife_pkg;
    typedef enum logic [1:0] {
        PIFE_QUAD_1X,
        PIFE_QUAD_2X,
        PIFE_QUAD_4X,
        PIFE_UP_DOWN
    } pife_method_t;
endpackage

// ==== rtl/pife_input_filter.sv ====
/*
 * three-flop synchroniser with optional long glitch filter for one pin.
 * assumes an asynchronous pin and the system clock.
 */
`timescale 1ns/1ps
`include "pife_defs.svh"

module pife_input_filter #(
    parameter int FILTER_CYCLES = `PIFE_FILTER_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    input wire logic filter_on_in,
    input wire logic reset_value_in,
    output logic level_out
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [31:0] stable_count;

    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            sync_c <= 1'b1;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // ----------------------------------------
    // glitch filter
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            level_out <= 1'b1;
            stable_count <= 32'h0;
        end else if (sync_b != sync_c) begin
            stable_count <= 32'h0;
        end else if (sync_c == level_out) begin
            stable_count <= 32'h0;
        end else if (!filter_on_in || stable_count >= 32'(FILTER_CYCLES - 1)) begin
            level_out <= sync_c;
            stable_count <= 32'h0;
        end else begin
            stable_count <= stable_count + 32'h1;
        end
    end
endmodule

// ==== rtl/pife_front_end.sv ====
/*
 * pulsar input front end of one axis: decode, scale, buffer, emit pulses.
 * assumes phase pins are asynchronous and a speed clock tick from the axis.
 */
`timescale 1ns/1ps
`include "pife_defs.svh"

module pife_front_end (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pulsar_phase_a_in,
    input wire logic pulsar_phase_b_in,
    input wire logic pulsar_enable_n_in,
    input wire logic [1:0] direction_switch_inputs_in,
    input wire logic [31:0] env_config_one_in,
    input wire logic [31:0] env_config_two_in,
    input wire logic [4:0] extra_multiplier_in,
    input wire logic [10:0] divider_numerator_in,
    input wire logic command_write_in,
    input wire logic [7:0] command_in,
    input wire logic speed_tick_in,
    input wire logic limit_plus_in,
    input wire logic limit_minus_in,
    input wire logic error_clear_in,
    output logic pulse_out,
    output logic direction_out,
    output logic running_out,
    output logic [3:0] operation_state_out,
    output logic [31:0] error_cause_out,
    output logic error_interrupt_out,
    output logic [1:0] direction_switch_filtered_out
);
    import pife_pkg::*;

    logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
    logic enable_n_level;
    logic active;
    logic decoded_up_pulse, decoded_down_pulse;
    logic simultaneous;
    logic sense;
    logic a_rise, a_fall, b_rise, b_fall, a_chg, b_chg;
    logic fwd_a, fwd_b;
    pife_method_t method;
    logic [4:0] mult_left;
    logic mult_dir;
    logic mult_pulse;
    logic [11:0] div_acc;
    logic [12:0] next_div_sum;
    logic scaled_pulse;
    logic [15:0] buffer_count;
    logic buffer_dir;
    logic overflow;
    logic accept_up, accept_down;

    // ----------------------------------------
    // pin synchronisers and filters
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            {a_s1, a_s2, a_s3} <= 3'h0;
            {b_s1, b_s2, b_s3} <= 3'h0;
        end else begin
            a_s1 <= pulsar_phase_a_in;
            a_s2 <= a_s1;
            a_s3 <= a_s2;
            b_s1 <= pulsar_phase_b_in;
            b_s2 <= b_s1;
            b_s3 <= b_s2;
        end
    end

    pife_input_filter u_enable_filter (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(pulsar_enable_n_in),
        .filter_on_in(env_config_one_in[`PIFE_ENV1_FILTER_BIT]),
        .reset_value_in(1'b1),
        .level_out(enable_n_level)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dir
            pife_input_filter u_dir_filter (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .pin_in(direction_switch_inputs_in[gi]),
                .filter_on_in(env_config_one_in[`PIFE_ENV1_FILTER_BIT]),
                .reset_value_in(1'b1),
                .level_out(direction_switch_filtered_out[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // decoder
    // ----------------------------------------
    always_comb begin
        method = pife_method_t'(env_config_two_in[`PIFE_ENV2_METHOD_LO +: 2]);
        sense = env_config_two_in[`PIFE_ENV2_SENSE_BIT];
        a_chg = a_s2 != a_s3;
        b_chg = b_s2 != b_s3;
        a_rise = a_s2 && !a_s3;
        a_fall = !a_s2 && a_s3;
        b_rise = b_s2 && !b_s3;
        b_fall = !b_s2 && b_s3;
        // edges that mean a leads b
        fwd_a = (a_rise && !b_s2) || (a_fall && b_s2) || (b_rise && a_s2) || (b_fall && !a_s2);
        fwd_b = (a_rise && b_s2) || (a_fall && !b_s2) || (b_rise && !a_s2) || (b_fall && a_s2);
        simultaneous = a_chg && b_chg;
        decoded_up_pulse = 1'b0;
        decoded_down_pulse = 1'b0;
        case (method)
            PIFE_QUAD_1X: begin
                decoded_up_pulse = a_rise && !b_s2;
                decoded_down_pulse = a_fall && !b_s2;
            end
            PIFE_QUAD_2X: begin
                decoded_up_pulse = a_chg && fwd_a;
                decoded_down_pulse = a_chg && fwd_b;
            end
            PIFE_QUAD_4X: begin
                decoded_up_pulse = fwd_a;
                decoded_down_pulse = fwd_b;
            end
            PIFE_UP_DOWN: begin
                decoded_up_pulse = a_rise;
                decoded_down_pulse = b_rise;
            end
            default: begin
                decoded_up_pulse = 1'b0;
                decoded_down_pulse = 1'b0;
            end
        endcase
        if (simultaneous) begin
            decoded_up_pulse = 1'b0;
            decoded_down_pulse = 1'b0;
        end
        if (sense) begin
            {decoded_up_pulse, decoded_down_pulse} = {decoded_down_pulse, decoded_up_pulse};
        end
        active = running_out && !enable_n_level && !env_config_two_in[`PIFE_ENV2_DISABLE_BIT];
        accept_up = active && decoded_up_pulse && !limit_plus_in;
        accept_down = active && decoded_down_pulse && !limit_minus_in;
    end

    // ----------------------------------------
    // start and stop
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            running_out <= 1'b0;
        end else if (command_write_in) begin
            if (command_in == `PIFE_CMD_START_LOW || command_in == `PIFE_CMD_START_HIGH) begin
                running_out <= 1'b1;
            end else if (command_in == `PIFE_CMD_IMMEDIATE_STOP) begin
                running_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            operation_state_out <= `PIFE_STATE_IDLE;
        end else if (running_out) begin
            operation_state_out <= `PIFE_STATE_WAIT_INPUT;
        end else begin
            operation_state_out <= `PIFE_STATE_IDLE;
        end
    end

    // ----------------------------------------
    // multiplier, one pulse per cycle
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mult_left <= 5'h0;
            mult_dir <= 1'b0;
            mult_pulse <= 1'b0;
        end else if (accept_up || accept_down) begin
            mult_left <= extra_multiplier_in;
            mult_dir <= accept_up;
            mult_pulse <= 1'b1;
        end else if (mult_left != 5'h0 && running_out) begin
            mult_left <= mult_left - 5'h1;
            mult_pulse <= 1'b1;
        end else begin
            mult_left <= 5'h0;
            mult_pulse <= 1'b0;
        end
    end

    // ----------------------------------------
    // n/2048 divider
    // ----------------------------------------
    always_comb begin
        next_div_sum = {1'b0, div_acc} + {2'b00, divider_numerator_in};
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_acc <= 12'h0;
            scaled_pulse <= 1'b0;
        end else if (!mult_pulse) begin
            scaled_pulse <= 1'b0;
        end else if (divider_numerator_in == 11'h0) begin
            scaled_pulse <= 1'b1;
        end else if (next_div_sum >= {1'b0, `PIFE_DIV_FULL}) begin
            div_acc <= 12'(next_div_sum - {1'b0, `PIFE_DIV_FULL});
            scaled_pulse <= 1'b1;
        end else begin
            div_acc <= next_div_sum[11:0];
            scaled_pulse <= 1'b0;
        end
    end

    // ----------------------------------------
    // buffer counter and output gating
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            buffer_count <= 16'h0;
            buffer_dir <= 1'b0;
            overflow <= 1'b0;
            pulse_out <= 1'b0;
            direction_out <= 1'b0;
        end else if (!running_out) begin
            buffer_count <= 16'h0;
            overflow <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            overflow <= 1'b0;
            pulse_out <= 1'b0;
            if (scaled_pulse && (buffer_count == 16'h0 || buffer_dir == mult_dir)) begin
                buffer_dir <= mult_dir;
                if (speed_tick_in) begin
                    pulse_out <= 1'b1;
                    direction_out <= mult_dir;
                end else if (buffer_count == `PIFE_BUF_MAX) begin
                    overflow <= 1'b1;
                end else begin
                    buffer_count <= buffer_count + 16'h1;
                end
            end else if (scaled_pulse) begin
                buffer_count <= buffer_count - 16'h1;
            end else if (speed_tick_in && buffer_count != 16'h0) begin
                buffer_count <= buffer_count - 16'h1;
                pulse_out <= 1'b1;
                direction_out <= buffer_dir;
            end
        end
    end

    // ----------------------------------------
    // error cause and error output
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            error_cause_out <= 32'h0;
            error_interrupt_out <= 1'b0;
        end else begin
            if (error_clear_in) begin
                error_cause_out <= 32'h0;
                error_interrupt_out <= 1'b0;
            end
            if (active && simultaneous) begin
                error_cause_out[`PIFE_ERR_SIMUL_BIT] <= 1'b1;
                error_interrupt_out <= 1'b1;
            end
            if (overflow) begin
                error_cause_out[`PIFE_ERR_OVERFLOW_BIT] <= 1'b1;
                error_interrupt_out <= 1'b1;
            end
        end
    end
endmodule

// ==== testbench/pife_checker.sv ====
/* port assertions of the pulsar front end.
   assumes binding to every pife_front_end instance. */
`timescale 1ns/1ps
module pife_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pulsar_phase_a_in,
    input wire logic pulsar_phase_b_in,
    input wire logic pulsar_enable_n_in,
    input wire logic [31:0] env_config_two_in,
    input wire logic command_write_in,
    input wire logic [7:0] command_in,
    input wire logic speed_tick_in,
    input wire logic error_clear_in,
    input wire logic pulse_out,
    input wire logic running_out,
    input wire logic [3:0] operation_state_out,
    input wire logic [31:0] error_cause_out,
    input wire logic error_interrupt_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // ----------
    // properties
    // ----------
    AST_PULSE_TICK: assert property (pulse_out |-> $past(speed_tick_in))
        else $error("pulse without speed tick");
    AST_PULSE_RUN: assert property (pulse_out |-> $past(running_out))
        else $error("pulse while stopped");
    AST_START: assert property (command_write_in && !running_out &&
        (command_in == 8'h50 || command_in == 8'h51) |=> running_out)
        else $error("start not taken");
    AST_STOP: assert property (command_write_in && command_in == 8'h49
        |=> !running_out ##1 operation_state_out == 4'h0)
        else $error("stop not taken");
    AST_STATE_RUN: assert property (running_out && $past(running_out)
        |-> operation_state_out == 4'h8)
        else $error("state not waiting");
    AST_ERR_HOLD: assert property (error_interrupt_out && !error_clear_in
        |=> error_interrupt_out)
        else $error("error output dropped");
    AST_ERR_CAUSE: assert property ($rose(error_interrupt_out)
        |-> error_cause_out[17] || error_cause_out[14])
        else $error("error without cause");
    AST_SIMUL: assert property (running_out && !env_config_two_in[31] &&
        !pulsar_enable_n_in && $changed(pulsar_phase_a_in) && $changed(pulsar_phase_b_in)
        |-> ##[1:6] error_cause_out[17] && error_interrupt_out)
        else $error("simultaneous edge missed");
    AST_CLEAR: assert property (error_clear_in && !running_out
        |=> error_cause_out == 32'h0 && !error_interrupt_out)
        else $error("error not cleared");
    COV_PULSE: cover property (pulse_out);
    COV_SIMUL: cover property (error_cause_out[17]);
    COV_OVER: cover property (error_cause_out[14]);
endmodule
bind pife_front_end pife_checker i_pife_checker (.clk_in, .reset_in, .pulsar_phase_a_in,
    .pulsar_phase_b_in, .pulsar_enable_n_in, .env_config_two_in, .command_write_in,
    .command_in, .speed_tick_in, .error_clear_in, .pulse_out, .running_out,
    .operation_state_out, .error_cause_out, .error_interrupt_out);

// ==== testbench/pife_pulsar_gen.sv ====
/* manual pulse generator model driving the phase and enable pins.
   assumes the bench calls its tasks; pins change at falling edges. */
`timescale 1ns/1ps
module pife_pulsar_gen #(
    parameter int GAP = 34
) (
    input wire logic clk_in,
    output logic phase_a_out,
    output logic phase_b_out,
    output logic enable_n_out
);
    initial begin
        phase_a_out = 0;
        phase_b_out = 0;
        enable_n_out = 1;
    end
    task automatic set_en(input bit v);
        enable_n_out = v;
    endtask
    // spacing keeps the rate under the limit at its shortest period
    task automatic wait_gap();
        repeat (GAP) @(negedge clk_in);
    endtask
    // gray steps, no reversal inside one call
    task automatic quad(input bit fwd, input int n);
        for (int i = 0; i < 4 * n; i++) begin
            wait_gap();
            if (phase_a_out ^ phase_b_out ^ fwd) begin
                phase_a_out = !phase_a_out;
            end else begin
                phase_b_out = !phase_b_out;
            end
        end
    endtask
    task automatic updown(input bit fwd, input int n);
        for (int i = 0; i < n; i++) begin
            wait_gap();
            if (fwd) phase_a_out = 1;
            else phase_b_out = 1;
            wait_gap();
            phase_a_out = 0;
            phase_b_out = 0;
        end
    endtask
    task automatic clash();
        repeat (2) begin
            wait_gap();
            phase_a_out = !phase_a_out;
            phase_b_out = !phase_b_out;
        end
    endtask
endmodule

// ==== testbench/pife_front_end_tb.sv ====
/* self-checking bench of the pulsar front end.
   assumes the generator model and the bound checker. */
`timescale 1ns/1ps
`include "pife_defs.svh"
module pife_front_end_tb;
    logic clk_in = 0;
    logic reset_in = 1;
    logic pulsar_phase_a_in, pulsar_phase_b_in, pulsar_enable_n_in;
    logic [1:0] direction_switch_inputs_in = 0;
    logic [31:0] env_config_one_in = 0;
    logic [31:0] env_config_two_in = 0;
    logic [4:0] extra_multiplier_in = 0;
    logic [10:0] divider_numerator_in = 0;
    logic command_write_in = 0, speed_tick_in = 0, limit_plus_in = 0, limit_minus_in = 0;
    logic error_clear_in = 0;
    logic [7:0] command_in = 0;
    logic pulse_out, direction_out, running_out, error_interrupt_out;
    logic [3:0] operation_state_out;
    logic [31:0] error_cause_out;
    logic [1:0] direction_switch_filtered_out;
    int fails = 0, checks = 0, cyc = 0, nf = 0, nr = 0;
    bit tick_en = 1;
    always #2.5 clk_in = !clk_in;
    pife_pulsar_gen #(.GAP(34)) i_pife_pulsar_gen (.clk_in, .phase_a_out(pulsar_phase_a_in),
        .phase_b_out(pulsar_phase_b_in), .enable_n_out(pulsar_enable_n_in));
    pife_front_end i_pife_front_end (.clk_in, .reset_in, .pulsar_phase_a_in,
        .pulsar_phase_b_in, .pulsar_enable_n_in, .direction_switch_inputs_in,
        .env_config_one_in, .env_config_two_in, .extra_multiplier_in, .divider_numerator_in,
        .command_write_in, .command_in, .speed_tick_in, .limit_plus_in, .limit_minus_in,
        .error_clear_in, .pulse_out, .direction_out, .running_out, .operation_state_out,
        .error_cause_out, .error_interrupt_out, .direction_switch_filtered_out);
    always @(negedge clk_in) speed_tick_in <= tick_en & 1'($urandom % 2);
    always @(negedge clk_in) begin
        cyc++;
        if (pulse_out === 1'b1 && direction_out === 1'b1) nf++;
        if (pulse_out === 1'b1 && direction_out !== 1'b1) nr++;
        if (cyc == 95000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        @(negedge clk_in);
        command_in = c;
        command_write_in = 1;
        @(negedge clk_in);
        command_write_in = 0;
    endtask
    task automatic start();
        cmd($urandom % 2 ? `PIFE_CMD_START_HIGH : `PIFE_CMD_START_LOW);
        check(running_out, 1);
        @(negedge clk_in);
        check(operation_state_out, `PIFE_STATE_WAIT_INPUT);
        nf = 0;
        nr = 0;
    endtask
    task automatic stop();
        cmd(`PIFE_CMD_IMMEDIATE_STOP);
        check(running_out, 0);
        @(negedge clk_in);
        check(operation_state_out, `PIFE_STATE_IDLE);
    endtask
    task automatic drain();
        int idle;
        idle = 0;
        while (idle < 300) begin
            @(negedge clk_in);
            idle = (pulse_out === 1'b1) ? 0 : idle + 1;
        end
    endtask
    // ----------
    // model: counts per cycle, multiplier, divider, gating
    // ----------
    task automatic run_case(input int m, input bit s, input int mul, input int dv,
        input bit fw, input bit go, input bit off, input bit en, input bit [1:0] lim,
        input int n);
        int e;
        bit d;
        d = fw ^ s;
        e = ((m == 3) ? n : n * (1 << m)) * (mul + 1);
        if (dv != 0) e = e * dv / 2048;
        if (!go || off || en || lim[d ? 0 : 1]) e = 0;
        @(negedge clk_in);
        env_config_two_in = {off, 4'h0, s, m[1:0], 24'h0};
        extra_multiplier_in = mul[4:0];
        divider_numerator_in = dv[10:0];
        {limit_minus_in, limit_plus_in} = lim;
        direction_switch_inputs_in = 2'($urandom);
        i_pife_pulsar_gen.set_en(en);
        nf = 0;
        nr = 0;
        if (go) start();
        if (m == 3) i_pife_pulsar_gen.updown(fw, n);
        else i_pife_pulsar_gen.quad(fw, n);
        drain();
        check(nf, d ? e : 0);
        check(nr, d ? 0 : e);
        check(error_cause_out, 0);
        check(direction_switch_filtered_out, direction_switch_inputs_in);
        if (go) stop();
        $display("case m=%0d s=%0d mul=%0d dv=%0d done", m, s, mul, dv);
    endtask
    initial begin
        void'($urandom(32'h6179));
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 0;
        repeat (4) @(negedge clk_in);
        run_case(2, 0, 0, 0, 1, 0, 0, 0, 2'b00, 2);
        run_case(0, 0, 0, 0, 1, 1, 0, 0, 2'b00, 3);
        run_case(1, 0, 0, 0, 0, 1, 0, 0, 2'b00, 3);
        run_case(2, 0, 2, 0, 1, 1, 0, 0, 2'b00, 2);
        run_case(3, 0, 0, 0, 1, 1, 0, 0, 2'b00, 5);
        run_case(3, 1, 0, 0, 1, 1, 0, 0, 2'b00, 4);
        run_case(2, 1, 0, 0, 1, 1, 0, 0, 2'b00, 2);
        run_case(0, 0, 31, 0, 1, 1, 0, 0, 2'b00, 2);
        run_case(2, 0, 0, 1024, 1, 1, 0, 0, 2'b00, 4);
        run_case(2, 0, 0, 0, 1, 1, 1, 0, 2'b00, 2);
        run_case(2, 0, 0, 0, 1, 1, 0, 1, 2'b00, 2);
        run_case(2, 0, 0, 0, 1, 1, 0, 0, 2'b01, 2);
        run_case(2, 0, 0, 0, 0, 1, 0, 0, 2'b01, 2);
        run_case(2, 0, 0, 0, 0, 1, 0, 0, 2'b10, 2);
        {limit_minus_in, limit_plus_in} = 2'b00;
        start();
        i_pife_pulsar_gen.clash();
        repeat (8) @(negedge clk_in);
        check(error_cause_out[17], 1);
        check(error_interrupt_out, 1);
        check(nf + nr, 0);
        stop();
        error_clear_in = 1;
        @(negedge clk_in);
        error_clear_in = 0;
        check(error_cause_out, 0);
        $display("simultaneous edge test done");
        extra_multiplier_in = 5'h1f;
        tick_en = 0;
        start();
        i_pife_pulsar_gen.quad(1, 520);
        repeat (8) @(negedge clk_in);
        check(error_cause_out[14], 1);
        check(error_interrupt_out, 1);
        $display("overflow test done");
        give_verdict();
    end
endmodule
